// ---- rtl/refresh_control_unit.sv ----
// memory refresh control unit with its apb register slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Periodically run a memory read bus cycle refreshing external memory, unprompted.
// - A 9-bit clock counter raises a refresh request each programmed interval.
// - A 12-bit row generator drives address lines a1 to a12 during refresh.
// - Address bits a13 to a19 come from a programmed base value.
// - In idle mode refresh request generation keeps running normally.
// - In powerdown counting halts; a refresh already pending still completes and steps the row, the other registers are kept.
module refresh_control_unit
    import refresh_pkg::*;
(
    input  wire logic                    CLK_I,
    input  wire logic                    RSTN_I,
    input  wire refresh_pkg::apb_req_t   APB_REQ_I,
    output refresh_pkg::apb_rsp_t        APB_RSP_O,
    input  wire logic                    IDLE_I,
    input  wire logic                    POWERDOWN_I,
    input  wire logic                    REFRESH_DONE_I,
    output logic                         REFRESH_REQ_O,
    output logic [19:0]                  REFRESH_ADDR_O
);
    import refresh_pkg::*;

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[IDX_SHIFT +: 8];
    endfunction

    // only the four aligned refresh words decode; anything else answers with pslverr
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = reg_index(a);
        reg_mapped = (a[IDX_SHIFT-1:0] == 2'h0) && (a[ADDR_W-1:IDX_SHIFT+8] == 2'h0)
                     && (i == IDX_BASE || i == IDX_TIME || i == IDX_CONTROL
                         || i == IDX_ADDRESS);
    endfunction

    // reset is taken at once but released through two flops, so no register
    // leaves reset on an edge that sits too close to the pin's release
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // the request flag is a two-state machine: waiting for an interval to expire,
    // or holding a refresh read up until the bus unit reports it complete
    typedef enum logic [0:0] {
        REQ_IDLE = 1'b0,
        REQ_PEND = 1'b1
    } req_state_t;

    logic [UPPER_W-1:0] upper_q;
    logic [UPPER_W-1:0] upper_d;
    logic [CNT_W-1:0]   interval_q;
    logic [CNT_W-1:0]   interval_d;
    logic               enable_q;
    logic               enable_d;
    logic [ROW_W-1:0]   row_q;
    logic [ROW_W-1:0]   row_d;
    req_state_t         req_q;
    req_state_t         req_d;
    logic [19:0]        addr_q;
    logic [19:0]        addr_d;
    apb_rsp_t           rsp_q;
    apb_rsp_t           rsp_d;

    // links between the counter, the bus slave and the request machine
    logic               expire;
    logic [CNT_W-1:0]   count;
    logic               run;
    logic               wr_take;
    logic               done;
    logic [7:0]         idx;

    // idle freezes only the execution and bus clocks, so it does not gate counting
    assign run = enable_q && !POWERDOWN_I;

    // the counter reloads from the programmed interval on expiry, so a new
    // interval written by software takes effect from the next request on
    refresh_interval_counter refresh_interval_counter_inst (
        .clk_i      (CLK_I),
        .rst_n_i    (rst_n_q),
        .run_i      (run),
        .interval_i (interval_q),
        .expire_o   (expire),
        .count_o    (count)
    );

    assign idx     = reg_index(APB_REQ_I.paddr);
    // a write lands only at the access edge that also sees pready, never in setup
    assign wr_take = APB_REQ_I.psel && APB_REQ_I.penable && rsp_q.pready
                     && APB_REQ_I.pwrite && reg_mapped(APB_REQ_I.paddr);
    // a completion pulse with no request outstanding is ignored
    assign done    = (req_q == REQ_PEND) && REFRESH_DONE_I;

    always_comb begin
        upper_d    = upper_q;
        interval_d = interval_q;
        enable_d   = enable_q;
        if (wr_take) begin
            case (idx)
                IDX_BASE: begin
                    upper_d = APB_REQ_I.pwdata[UPPER_W-1:0];
                end
                IDX_TIME: begin
                    interval_d = APB_REQ_I.pwdata[CNT_W-1:0];
                end
                IDX_CONTROL: begin
                    enable_d = APB_REQ_I.pwdata[ENABLE_B];
                end
                default: begin
                    upper_d = upper_q;
                end
            endcase
        end
    end

    always_comb begin
        req_d = req_q;
        row_d = row_q;
        if (done) begin
            row_d = row_q + ROW_STEP;
        end
        case (req_q)
            REQ_IDLE: begin
                if (expire) begin
                    req_d = REQ_PEND;
                end
            end
            REQ_PEND: begin
                // a new interval expiring in the completion cycle keeps the request up
                if (done && !expire) begin
                    req_d = REQ_IDLE;
                end
            end
            default: begin
                req_d = REQ_IDLE;
            end
        endcase
        // a0 is held low: refresh reads are word aligned
        addr_d = {upper_q, row_d, 1'b0};
    end

    always_comb begin
        // zero wait states: the answer is registered from the setup cycle
        rsp_d         = '0;
        rsp_d.pready  = APB_REQ_I.psel && !APB_REQ_I.penable;
        rsp_d.pslverr = rsp_d.pready && !reg_mapped(APB_REQ_I.paddr);
        if (rsp_d.pready && !APB_REQ_I.pwrite) begin
            case (idx)
                IDX_BASE: begin
                    rsp_d.prdata[UPPER_W-1:0] = upper_q;
                end
                IDX_TIME: begin
                    rsp_d.prdata[CNT_W-1:0] = interval_q;
                end
                IDX_CONTROL: begin
                    rsp_d.prdata[ENABLE_B]  = enable_q;
                    rsp_d.prdata[REQ_B]     = (req_q == REQ_PEND);
                    rsp_d.prdata[CNT_W-1:0] = count;
                end
                IDX_ADDRESS: begin
                    rsp_d.prdata[ROW_W-1:0] = row_q;
                end
                default: begin
                    rsp_d.prdata = '0;
                end
            endcase
        end
    end

    // powerdown only stops counting; the settings below keep their values, while a pending refresh still completes and steps the row
    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            upper_q    <= UPPER_RST;
            interval_q <= TIME_RST;
            enable_q   <= 1'b0;
        end else begin
            upper_q    <= upper_d;
            interval_q <= interval_d;
            enable_q   <= enable_d;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            row_q  <= ROW_RST;
            req_q  <= REQ_IDLE;
            addr_q <= '0;
        end else begin
            row_q  <= row_d;
            req_q  <= req_d;
            addr_q <= addr_d;
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign APB_RSP_O      = rsp_q;
    assign REFRESH_REQ_O  = (req_q == REQ_PEND);
    assign REFRESH_ADDR_O = addr_q;

    // idle is accepted for completeness of the power interface but needs no action
    // peripheral clocks keep running in idle, so nothing here is gated by it
    logic idle_unused;
    assign idle_unused = IDLE_I;
endmodule
`default_nettype wire

// ---- rtl/refresh_pkg.sv ----
// shared constants and types of the memory refresh control unit
package refresh_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_BASE    = 8'hB0;
    localparam logic [7:0] IDX_TIME    = 8'hB2;
    localparam logic [7:0] IDX_CONTROL = 8'hB4;
    localparam logic [7:0] IDX_ADDRESS = 8'hB6;
    localparam int         IDX_SHIFT   = 2;

    // field layout
    localparam int CNT_W     = 9;
    localparam int ROW_W     = 12;
    localparam int UPPER_W   = 7;
    localparam int ENABLE_B  = 15;
    localparam int REQ_B     = 14;

    localparam logic [CNT_W-1:0]   TIME_RST  = 9'h000;
    localparam logic [UPPER_W-1:0] UPPER_RST = 7'h00;
    localparam logic [ROW_W-1:0]   ROW_RST   = 12'h000;
    localparam logic [ROW_W-1:0]   ROW_STEP  = 12'h001;
    localparam logic [CNT_W-1:0]   CNT_ONE   = 9'h001;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;
endpackage

// ---- rtl/refresh_interval_counter.sv ----
// clock counter that spaces successive refresh requests
`timescale 1ns/100ps
`default_nettype none
module refresh_interval_counter
    import refresh_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             run_i,
    input  wire logic [CNT_W-1:0] interval_i,
    output logic                  expire_o,
    output logic [CNT_W-1:0]      count_o
);
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             expire_q;
    logic             expire_d;

    always_comb begin
        count_d  = count_q;
        expire_d = 1'b0;
        if (!run_i) begin
            // halted counting keeps its value, so a resume picks up where it stopped
            count_d = count_q;
        end else if (count_q <= CNT_ONE) begin
            count_d  = interval_i;
            expire_d = 1'b1;
        end else begin
            count_d = count_q - CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q  <= TIME_RST;
            expire_q <= 1'b0;
        end else begin
            count_q  <= count_d;
            expire_q <= expire_d;
        end
    end

    assign expire_o = expire_q;
    assign count_o  = count_q;
endmodule
`default_nettype wire

// ---- bench/refresh_checker.sv ----
// assertions on the refresh control unit ports
`timescale 1ns/100ps
`default_nettype none
module refresh_checker
    import refresh_pkg::*;
(
    input wire logic                  CLK_I,
    input wire logic                  RSTN_I,
    input wire refresh_pkg::apb_req_t APB_REQ_I,
    input wire refresh_pkg::apb_rsp_t APB_RSP_O,
    input wire logic                  IDLE_I,
    input wire logic                  POWERDOWN_I,
    input wire logic                  REFRESH_DONE_I,
    input wire logic                  REFRESH_REQ_O,
    input wire logic [19:0]           REFRESH_ADDR_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    wire logic fin = REFRESH_REQ_O && REFRESH_DONE_I;
    wire logic wr  = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite;
    a_req_holds: assert property (REFRESH_REQ_O && !REFRESH_DONE_I |=> REFRESH_REQ_O)
        else $error("refresh request dropped before completion");
    a_row_step: assert property (fin |=> REFRESH_ADDR_O[12:1] == $past(REFRESH_ADDR_O[12:1]) + 12'h001)
        else $error("row did not advance by one");
    a_row_hold: assert property (!fin |=> $stable(REFRESH_ADDR_O[12:1]))
        else $error("row moved without a completed refresh");
    a_bit0_low: assert property (REFRESH_ADDR_O[0] == 1'b0)
        else $error("refresh address bit 0 not low");
    a_pd_quiet: assert property (POWERDOWN_I [*4] |-> !$rose(REFRESH_REQ_O))
        else $error("refresh request raised in powerdown");
    a_ready_once: assert property (APB_REQ_I.psel && !APB_REQ_I.penable |=> APB_RSP_O.pready ##1 !APB_RSP_O.pready)
        else $error("ready not a single pulse after setup");
    a_upper_src: assert property ($changed(REFRESH_ADDR_O[19:13]) |-> $past(wr, 1) || $past(wr, 2))
        else $error("upper refresh bits changed without a write");
    cover property (fin);
    cover property (IDLE_I && $rose(REFRESH_REQ_O));
    cover property (POWERDOWN_I && REFRESH_REQ_O);
endmodule
`default_nettype wire

// ---- bench/refresh_bus_model.sv ----
// far side bus unit that completes refresh reads, promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module refresh_bus_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic slow_i,
    input  wire logic req_i,
    output logic      done_o
);
    logic [2:0] wait_q;
    logic [2:0] wait_d;
    logic       done_d;
    always_comb begin
        wait_d = wait_q;
        done_d = 1'b0;
        // done_o guard stops a second pulse while the request falls
        if (req_i && !done_o) begin
            wait_d = wait_q + 3'h1;
            if (wait_q >= (slow_i ? 3'h5 : 3'h0)) begin
                wait_d = 3'h0;
                done_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 3'h0;
            done_o <= 1'b0;
        end else begin
            wait_q <= wait_d;
            done_o <= done_d;
        end
    end
endmodule
`default_nettype wire

// ---- bench/tb_refresh_control_unit.sv ----
// testbench of the refresh control unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_refresh_control_unit;
    import refresh_pkg::*;
    logic        clk, rstn, idle, pdown, slow, done, req, err;
    logic [19:0] addr;
    logic [31:0] rd;
    logic [11:0] row;
    apb_req_t    aq;
    apb_rsp_t    ar;
    int          mismatches, checked, n;
    refresh_control_unit refresh_control_unit_inst (.CLK_I(clk), .RSTN_I(rstn), .APB_REQ_I(aq),
        .APB_RSP_O(ar), .IDLE_I(idle), .POWERDOWN_I(pdown), .REFRESH_DONE_I(done),
        .REFRESH_REQ_O(req), .REFRESH_ADDR_O(addr));
    refresh_bus_model refresh_bus_model_inst (.clk_i(clk), .rst_n_i(rstn), .slow_i(slow),
        .req_i(req), .done_o(done));
    task report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) aq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk) aq.penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (ar.pready !== 1'b1 && ++n < 9);
        if (n >= 9) begin
            mismatches++;
            report_and_stop();
        end
        rd = ar.prdata;
        err = ar.pslverr;
        aq <= '0;
    endtask
    // counts edges up to the next rising request, then checks the address shown
    task wait_rise;
        n = 0;
        while (req === 1'b1 && n < 600) begin @(posedge clk); n++; end
        while (req !== 1'b1 && n < 600) begin @(posedge clk); n++; end
        if (n >= 600) begin
            mismatches++;
            report_and_stop();
        end
        `CHK(addr, {7'h55, row, 1'b0})
        row++;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rstn = 1'b0; idle = 1'b0; pdown = 1'b0; slow = 1'b0; aq = '0;
        mismatches = 0; checked = 0; row = 12'h000;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 12'h2C0, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, 12'h2D8, 32'hFFF);
        apb(1'b0, 12'h2D8, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h2FC, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 12'h2C0, 32'hFFFFFFD5);
        apb(1'b0, 12'h2C0, 32'h0);
        `CHK(rd, 32'h55)
        apb(1'b1, 12'h2C8, 32'hFFFFFE14);
        apb(1'b0, 12'h2C8, 32'h0);
        `CHK(rd, 32'h14)
        $display("test registers done");
        apb(1'b1, 12'h2D0, 32'h8000);
        wait_rise();
        for (int i = 0; i < 3; i++) begin
            if (i == 1) idle <= 1'b1;
            if (i == 2) slow <= 1'b1;
            wait_rise();
            `CHK(n, 20)
        end
        $display("test periodic done");
        pdown <= 1'b1;
        repeat (100) @(posedge clk);
        `CHK(addr, {7'h55, row, 1'b0})
        `CHK(req, 1'b0)
        apb(1'b0, 12'h2C8, 32'h0);
        `CHK(rd, 32'h14)
        // enable set, nothing pending, counter frozen two steps below the interval
        apb(1'b0, 12'h2D0, 32'h0);
        `CHK(rd, 32'h00008012)
        pdown <= 1'b0;
        // resuming from the frozen count gives the same spacing as a fresh interval
        wait_rise();
        `CHK(n, 20)
        $display("test powerdown done");
        report_and_stop();
    end
endmodule
bind refresh_control_unit refresh_checker refresh_checker_inst (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .APB_REQ_I(APB_REQ_I), .APB_RSP_O(APB_RSP_O), .IDLE_I(IDLE_I), .POWERDOWN_I(POWERDOWN_I),
    .REFRESH_DONE_I(REFRESH_DONE_I), .REFRESH_REQ_O(REFRESH_REQ_O), .REFRESH_ADDR_O(REFRESH_ADDR_O));
`default_nettype wire
